// *** common/mscr_pkg.sv ***
package mscr_pkg;

  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [7:0] ADDR_IRQ_IF_CTRL   = 8'h13;
  localparam logic [7:0] ADDR_RND_ST_CTRL   = 8'h14;
  localparam logic [7:0] ADDR_TRIG_FLT_CTRL = 8'h15;

  // ****************************************************
  // reset values and writable masks
  // ****************************************************
  localparam logic [7:0] RST_IRQ_IF_CTRL   = 8'h00;
  localparam logic [7:0] RST_RND_ST_CTRL   = 8'h00;
  localparam logic [7:0] RST_TRIG_FLT_CTRL = 8'h00;
  localparam logic [7:0] MSK_IRQ_IF_CTRL   = 8'h6e;
  localparam logic [7:0] MSK_RND_ST_CTRL   = 8'h6f;
  localparam logic [7:0] MSK_TRIG_FLT_CTRL = 8'hef;
  localparam logic [7:0] RDATA_UNMAPPED    = 8'h00;

  // ****************************************************
  // field positions, interrupt and interface control
  // ****************************************************
  localparam int BIT_GYRO_SLEEP   = 6;
  localparam int BIT_MERGE_IRQ    = 5;
  localparam int BIT_DATA_READY_PIN_MASK    = 3;
  localparam int BIT_TWI_DISABLE  = 2;
  localparam int BIT_GYRO_FIRST_LOWPASS_FILTER_ON = 1;

  // ****************************************************
  // field positions, rounding and self-test control
  // ****************************************************
  localparam int POS_ROUND     = 5;
  localparam int POS_GYRO_ST   = 2;
  localparam int POS_ACCEL_ST  = 0;

  // ****************************************************
  // field positions, trigger and filter control
  // ****************************************************
  localparam int POS_TRIG      = 5;
  localparam int BIT_OFS_WEIGHT = 3;
  localparam int POS_GYRO_BW   = 0;

  // ****************************************************
  // field codes
  // ****************************************************
  localparam logic [1:0] ST_NORMAL     = 2'h0;
  localparam logic [1:0] GYRO_ST_BAD   = 2'h2;
  localparam logic [1:0] ACCEL_ST_BAD  = 2'h3;
  localparam logic [2:0] TRIG_OFF      = 3'h0;
  localparam logic [2:0] TRIG_EDGE     = 3'h4;
  localparam logic [2:0] TRIG_LEVEL    = 3'h2;
  localparam logic [2:0] TRIG_LATCH    = 3'h3;
  localparam logic [2:0] TRIG_FIFO     = 3'h6;
  localparam logic [3:0] OFS_EXP_FINE   = 4'ha;
  localparam logic [3:0] OFS_EXP_COARSE = 4'h6;

  // data-enable trigger modes, one-hot
  typedef enum logic [5:0] {
    DEN_OFF   = 6'h01,
    DEN_EDGE  = 6'h02,
    DEN_LEVEL = 6'h04,
    DEN_LATCH = 6'h08,
    DEN_FIFO  = 6'h10,
    DEN_BAD   = 6'h20
  } mscr_den_mode_t;

endpackage : mscr_pkg

// *** verilog/mscr_ctrl_regs.sv ***
`timescale 1ns/1ps

// Function
// - gyro sleep bit set sleeps the rate sensor, clear wakes it; resets zero
// - merge bit one ORs all interrupt sources onto pin one; zero splits them
// - data-ready mask keeps each sensor's ready off the pin while its own filter settles
// - two-wire disable bit one turns off I2C, leaving SPI; resets zero
// - gyro first low-pass enable inserts filter, bandwidth from select field
// - rounding 00 none, 01 accel, 10 gyro, 11 both; resets 00
// - gyro self-test 00 normal, 01 positive, 11 negative; 10 forbidden
// - accel self-test 00 normal, 01 positive, 10 negative; 11 forbidden
// - trigger bits 100 select edge-sensitive data-enable mode
// - trigger bits 010 select level-sensitive data-enable mode
// - trigger bits 011 select level-sensitive latched mode
// - trigger bits 110 select level-sensitive FIFO enable mode
// - offset weight zero gives 2^-10 g per LSB, one gives 2^-6
// - bandwidth codes 100 to 111 unavailable at 3.33 and 6.67 kHz rates
module mscr_ctrl_regs #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                    CLK_I,
  input  wire logic                    RST_N_I,
  // register port
  input  wire logic [ADDR_W-1:0]       REG_ADDR_I,
  input  wire logic                    REG_WR_I,
  input  wire logic                    REG_RD_I,
  input  wire logic [7:0]              REG_WDATA_I,
  output logic      [7:0]              REG_RDATA_O,
  output logic                         REG_RVALID_O,
  // interrupt sources and pins
  input  wire logic                    IRQ_SRC_ONE_I,
  input  wire logic                    IRQ_SRC_TWO_I,
  output logic                         IRQ_PIN_ONE_O,
  output logic                         IRQ_PIN_TWO_O,
  // data-ready sources and pin
  input  wire logic                    ACCEL_DATA_READY_SIGNAL_I,
  input  wire logic                    GYRO_DATA_READY_SIGNAL_I,
  input  wire logic                    ACCEL_SETTLING_I,
  input  wire logic                    GYRO_SETTLING_I,
  output logic                         DATA_READY_PIN_O,
  // interface and power control
  output logic                         GYRO_SLEEP_O,
  output logic                         TWI_ENABLE_O,
  // gyro filter
  input  wire logic                    GYRO_ODR_HIGH_I,
  output logic                         GYRO_FIRST_LOWPASS_FILTER_ON_O,
  output logic      [2:0]              GYRO_BW_SEL_O,
  output logic                         GYRO_BW_BAD_O,
  // rounding and self-test
  output logic                         ROUND_ACCEL_O,
  output logic                         ROUND_GYRO_O,
  output logic      [1:0]              GYRO_ST_O,
  output logic      [1:0]              ACCEL_ST_O,
  output logic                         SELFTEST_BAD_O,
  // data-enable and offset weight
  output mscr_pkg::mscr_den_mode_t     DEN_MODE_O,
  output logic      [3:0]              OFS_LSB_EXP_O
);
  import mscr_pkg::*;

  // ****************************************************
  // elaboration check
  // ****************************************************
  // offsets reach 0x15, so five address bits at least
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr_w
    $error("mscr_ctrl_regs: ADDR_W must lie in 5..8");
  end

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic [7:0]     irq_if;
    logic [7:0]     rnd_st;
    logic [7:0]     trig_flt;
    logic [7:0]     rdata;
    logic           rvalid;
    logic           pin_one;
    logic           pin_two;
    logic           data_ready_signal_pin;
    logic [1:0]     gyro_st;
    logic [1:0]     accel_st;
    logic           st_bad;
    logic           bw_bad;
    logic           twi_en;
    mscr_den_mode_t data_enable_input;
    logic [3:0]     ofs_exp;
  } mscr_state_t;

  mscr_state_t st_r;
  mscr_state_t st_nxt;

  // ****************************************************
  // helpers
  // ****************************************************
  // widen the narrow address to byte width for compare
  function automatic logic [7:0] mscr_addr(
    input logic [ADDR_W-1:0] a
  );
    logic [7:0] w;
    w = '0;
    w[ADDR_W-1:0] = a;
    return w;
  endfunction : mscr_addr

  // decode the three trigger bits into a mode
  function automatic mscr_den_mode_t mscr_den(
    input logic [2:0] t
  );
    mscr_den_mode_t m;
    case (t)
      TRIG_OFF:   m = DEN_OFF;
      TRIG_EDGE:  m = DEN_EDGE;
      TRIG_LEVEL: m = DEN_LEVEL;
      TRIG_LATCH: m = DEN_LATCH;
      TRIG_FIFO:  m = DEN_FIFO;
      default:    m = DEN_BAD;
    endcase
    return m;
  endfunction : mscr_den

  // forbidden self-test code falls back to normal mode
  function automatic logic [1:0] mscr_st(
    input logic [1:0] code,
    input logic [1:0] bad
  );
    return (code == bad) ? ST_NORMAL : code;
  endfunction : mscr_st

  // ****************************************************
  // next state
  // ****************************************************
  // values decoded from the next register image, so the
  // field outputs follow a write on the same edge
  always_comb begin
    logic [7:0] a;
    logic [1:0] gst;
    logic [1:0] xst;
    logic [2:0] bw;
    logic       m;
    gst    = ST_NORMAL;
    xst    = ST_NORMAL;
    bw     = 3'h0;
    m      = 1'b0;
    st_nxt = st_r;
    a      = mscr_addr(REG_ADDR_I);
    // register write; reserved bits forced low
    if (REG_WR_I) begin
      case (a)
        ADDR_IRQ_IF_CTRL:
          st_nxt.irq_if = REG_WDATA_I & MSK_IRQ_IF_CTRL;
        ADDR_RND_ST_CTRL:
          st_nxt.rnd_st = REG_WDATA_I & MSK_RND_ST_CTRL;
        ADDR_TRIG_FLT_CTRL:
          st_nxt.trig_flt = REG_WDATA_I & MSK_TRIG_FLT_CTRL;
        default: ;  // unmapped writes dropped
      endcase
    end
    // read returns the value held before a same-cycle write
    st_nxt.rvalid = REG_RD_I;
    if (REG_RD_I) begin
      case (a)
        ADDR_IRQ_IF_CTRL:   st_nxt.rdata = st_r.irq_if;
        ADDR_RND_ST_CTRL:   st_nxt.rdata = st_r.rnd_st;
        ADDR_TRIG_FLT_CTRL: st_nxt.rdata = st_r.trig_flt;
        default:            st_nxt.rdata = RDATA_UNMAPPED;
      endcase
    end
    // interrupt routing; merged onto pin one when set
    if (st_r.irq_if[BIT_MERGE_IRQ]) begin
      st_nxt.pin_one = IRQ_SRC_ONE_I | IRQ_SRC_TWO_I;
      st_nxt.pin_two = 1'b0;
    end else begin
      st_nxt.pin_one = IRQ_SRC_ONE_I;
      st_nxt.pin_two = IRQ_SRC_TWO_I;
    end
    // each sensor masked on its own settling window
    m = st_r.irq_if[BIT_DATA_READY_PIN_MASK];
    st_nxt.data_ready_signal_pin = (ACCEL_DATA_READY_SIGNAL_I & ~(m & ACCEL_SETTLING_I)) |
                      (GYRO_DATA_READY_SIGNAL_I & ~(m & GYRO_SETTLING_I));
    // self-test selections, forbidden codes neutralised
    gst = st_nxt.rnd_st[POS_GYRO_ST +: 2];
    xst = st_nxt.rnd_st[POS_ACCEL_ST +: 2];
    st_nxt.gyro_st  = mscr_st(gst, GYRO_ST_BAD);
    st_nxt.accel_st = mscr_st(xst, ACCEL_ST_BAD);
    st_nxt.st_bad   = (gst == GYRO_ST_BAD) |
                      (xst == ACCEL_ST_BAD);
    // upper bandwidth codes do not exist at the top rates
    bw = st_nxt.trig_flt[POS_GYRO_BW +: 3];
    st_nxt.bw_bad = st_nxt.irq_if[BIT_GYRO_FIRST_LOWPASS_FILTER_ON] &
                    GYRO_ODR_HIGH_I & bw[2];
    st_nxt.data_enable_input = mscr_den(st_nxt.trig_flt[POS_TRIG +: 3]);
    // offset weight as negative power of two per LSB
    st_nxt.ofs_exp = st_nxt.trig_flt[BIT_OFS_WEIGHT] ?
                     OFS_EXP_COARSE : OFS_EXP_FINE;
    // enable kept in its own flop so the port has no gate
    st_nxt.twi_en = ~st_nxt.irq_if[BIT_TWI_DISABLE];
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r.irq_if   <= RST_IRQ_IF_CTRL;
      st_r.rnd_st   <= RST_RND_ST_CTRL;
      st_r.trig_flt <= RST_TRIG_FLT_CTRL;
      st_r.rdata    <= RDATA_UNMAPPED;
      st_r.rvalid   <= 1'b0;
      st_r.pin_one  <= 1'b0;
      st_r.pin_two  <= 1'b0;
      st_r.data_ready_signal_pin <= 1'b0;
      st_r.gyro_st  <= ST_NORMAL;
      st_r.accel_st <= ST_NORMAL;
      st_r.st_bad   <= 1'b0;
      st_r.bw_bad   <= 1'b0;
      st_r.twi_en   <= 1'b1;
      st_r.data_enable_input      <= DEN_OFF;
      st_r.ofs_exp  <= OFS_EXP_FINE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************
  // outputs, all straight from the state register
  // ****************************************************
  // register port
  assign REG_RDATA_O      = st_r.rdata;
  assign REG_RVALID_O     = st_r.rvalid;
  // pins
  assign IRQ_PIN_ONE_O    = st_r.pin_one;
  assign IRQ_PIN_TWO_O    = st_r.pin_two;
  assign DATA_READY_PIN_O = st_r.data_ready_signal_pin;
  // power and interface
  assign GYRO_SLEEP_O     = st_r.irq_if[BIT_GYRO_SLEEP];
  // enable flop, high out of reset
  assign TWI_ENABLE_O     = st_r.twi_en;
  // gyro filter
  assign GYRO_FIRST_LOWPASS_FILTER_ON_O   = st_r.irq_if[BIT_GYRO_FIRST_LOWPASS_FILTER_ON];
  assign GYRO_BW_SEL_O    = st_r.trig_flt[POS_GYRO_BW +: 3];
  assign GYRO_BW_BAD_O    = st_r.bw_bad;
  // rounding: low bit accel, high bit gyro
  assign ROUND_ACCEL_O    = st_r.rnd_st[POS_ROUND];
  assign ROUND_GYRO_O     = st_r.rnd_st[POS_ROUND+1];
  // self-test
  assign GYRO_ST_O        = st_r.gyro_st;
  assign ACCEL_ST_O       = st_r.accel_st;
  assign SELFTEST_BAD_O   = st_r.st_bad;
  // data-enable mode and offset weight
  assign DEN_MODE_O       = st_r.data_enable_input;
  assign OFS_LSB_EXP_O    = st_r.ofs_exp;

endmodule : mscr_ctrl_regs

// *** bench/mscr_host_model.sv ***
`timescale 1ns/1ps
// ****
// host side of the register port
// ****
module mscr_host_model (
  input  wire logic       clk_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  int idle = 0;
  // quiet bus at time zero
  initial begin
    {addr_o, wdata_o, wr_o, rd_o} = 18'h0;
  end
  // bad codes only when a test asks for them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d; // released data must not look valid
    repeat (idle + 1) @(posedge clk_i);
  endtask : wr
  // idle gap keeps strobes apart and models a slow host
  task automatic rd(input logic [7:0] a);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    repeat (idle + 1) @(posedge clk_i);
  endtask : rd
endmodule : mscr_host_model

// *** bench/mscr_ctrl_regs_assertions.sv ***
`timescale 1ns/1ps
// ****
// control register checker
// ****
module mscr_ctrl_regs_chk #(
  parameter int ADDR_W = 8
) (
  input wire logic              CLK_I, RST_N_I, REG_WR_I,
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic [7:0]        REG_WDATA_I,
  input wire logic              IRQ_SRC_ONE_I, IRQ_SRC_TWO_I,
  input wire logic              IRQ_PIN_ONE_O, IRQ_PIN_TWO_O,
  input wire logic              ACCEL_DATA_READY_SIGNAL_I, GYRO_DATA_READY_SIGNAL_I,
  input wire logic              ACCEL_SETTLING_I, GYRO_SETTLING_I,
  input wire logic              DATA_READY_PIN_O, GYRO_SLEEP_O,
  input wire logic              TWI_ENABLE_O, GYRO_ODR_HIGH_I,
  input wire logic              GYRO_FIRST_LOWPASS_FILTER_ON_O, GYRO_BW_BAD_O,
  input wire logic [2:0]        GYRO_BW_SEL_O,
  input wire logic              SELFTEST_BAD_O,
  input mscr_pkg::mscr_den_mode_t DEN_MODE_O,
  input wire logic [3:0]        OFS_LSB_EXP_O
);
  import mscr_pkg::*;
  logic live, mg, mk;
  wire logic w13 = REG_WR_I && REG_ADDR_I == ADDR_W'(ADDR_IRQ_IF_CTRL);
  wire logic w14 = REG_WR_I && REG_ADDR_I == ADDR_W'(ADDR_RND_ST_CTRL);
  wire logic w15 = REG_WR_I && REG_ADDR_I == ADDR_W'(ADDR_TRIG_FLT_CTRL);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // shadow routing bits; live skips the first edge, pins lag a cycle
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      {live, mg, mk} <= 3'h0;
    end else begin
      live <= 1'b1;
      if (w13) begin
        {mg, mk} <= {REG_WDATA_I[BIT_MERGE_IRQ], REG_WDATA_I[BIT_DATA_READY_PIN_MASK]};
      end
    end
  end
  a_sleep_bit: assert property (w13 |=> GYRO_SLEEP_O == $past(REG_WDATA_I[6]))
    else $error("gyro sleep wrong");
  a_twi_off: assert property (w13 |=> TWI_ENABLE_O != $past(REG_WDATA_I[2]))
    else $error("two-wire enable wrong");
  a_pin_one: assert property (live |-> IRQ_PIN_ONE_O ==
    $past(IRQ_SRC_ONE_I | (mg & IRQ_SRC_TWO_I))) else $error("pin one wrong");
  a_pin_two: assert property (live |-> IRQ_PIN_TWO_O ==
    $past(IRQ_SRC_TWO_I & !mg)) else $error("pin two wrong");
  a_data_ready_pin_mask: assert property (live |-> DATA_READY_PIN_O == $past(
    (ACCEL_DATA_READY_SIGNAL_I & !(mk & ACCEL_SETTLING_I)) |
    (GYRO_DATA_READY_SIGNAL_I & !(mk & GYRO_SETTLING_I)))) else $error("data_ready_signal pin wrong");
  a_den_edge: assert property (w15 && REG_WDATA_I[7:5] == TRIG_EDGE
    |=> DEN_MODE_O == DEN_EDGE) else $error("edge mode wrong");
  a_ofs_weight: assert property (w15 |=> OFS_LSB_EXP_O ==
    ($past(REG_WDATA_I[3]) ? OFS_EXP_COARSE : OFS_EXP_FINE))
    else $error("offset weight wrong");
  a_st_flag: assert property (w14 |=> SELFTEST_BAD_O == $past(
    REG_WDATA_I[3:2] == GYRO_ST_BAD || REG_WDATA_I[1:0] == ACCEL_ST_BAD))
    else $error("self-test flag wrong");
  a_bw_flag: assert property (GYRO_BW_BAD_O == (GYRO_FIRST_LOWPASS_FILTER_ON_O &
    $past(GYRO_ODR_HIGH_I) & GYRO_BW_SEL_O[2])) else $error("bw flag wrong");
  c_merge: cover property (mg && IRQ_SRC_TWO_I);
  c_mask: cover property (mk && ACCEL_SETTLING_I && ACCEL_DATA_READY_SIGNAL_I);
  c_bw_bad: cover property (GYRO_BW_BAD_O);
endmodule : mscr_ctrl_regs_chk
bind mscr_ctrl_regs mscr_ctrl_regs_chk #(.ADDR_W(ADDR_W)) chk_u (.*);

// *** bench/tb_motion_sensor_control_regs.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) chk(n, 8'(e), 8'(g))
module tb_motion_sensor_control_regs;
  import mscr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] rin = 7'h00;
  logic [7:0] addr, wdata, rdata, v;
  logic wr, rd, rvalid, p1, p2, data_ready_signal, sleep, twi, lpf, bwbad;
  logic rnda, rndg, stbad;
  logic [2:0] bw;
  logic [1:0] gst, ast;
  logic [3:0] ofs;
  mscr_den_mode_t data_enable_input;
  logic [7:0] expq[$];
  int tests_run = 0;
  int miscompares = 0;
  int cyc = 0;
  mscr_ctrl_regs dut_u (
    .CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvalid), .IRQ_SRC_ONE_I(rin[0]), .IRQ_SRC_TWO_I(rin[1]),
    .IRQ_PIN_ONE_O(p1), .IRQ_PIN_TWO_O(p2), .ACCEL_DATA_READY_SIGNAL_I(rin[2]),
    .GYRO_DATA_READY_SIGNAL_I(rin[3]), .ACCEL_SETTLING_I(rin[4]),
    .GYRO_SETTLING_I(rin[5]), .DATA_READY_PIN_O(data_ready_signal),
    .GYRO_SLEEP_O(sleep), .TWI_ENABLE_O(twi), .GYRO_ODR_HIGH_I(rin[6]),
    .GYRO_FIRST_LOWPASS_FILTER_ON_O(lpf), .GYRO_BW_SEL_O(bw), .GYRO_BW_BAD_O(bwbad),
    .ROUND_ACCEL_O(rnda), .ROUND_GYRO_O(rndg), .GYRO_ST_O(gst),
    .ACCEL_ST_O(ast), .SELFTEST_BAD_O(stbad), .DEN_MODE_O(data_enable_input),
    .OFS_LSB_EXP_O(ofs));
  mscr_host_model host_u (.clk_i(clk), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  always #10 clk = ~clk;
  // random pin inputs every cycle
  always @(posedge clk) rin <= 7'($urandom);
  task automatic chk(input string n, input logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // note the expected byte, then read
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    host_u.rd(a);
  endtask : rdchk
  function automatic mscr_den_mode_t dmode(input logic [2:0] t);
    case (t)
      3'h0: return DEN_OFF;
      3'h4: return DEN_EDGE;
      3'h2: return DEN_LEVEL;
      3'h3: return DEN_LATCH;
      3'h6: return DEN_FIFO;
      default: return DEN_BAD;
    endcase
  endfunction : dmode
  // read answers are matched against the oldest note
  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      if (expq.size() == 0) `CHK("spare rvalid", 8'h00, 8'hff);
      else `CHK("rdata", expq.pop_front(), rdata);
    end
  end
  // hang guard, far above the under one thousand cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(90464));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("twi", 1'b1, twi);
    `CHK("ofs", OFS_EXP_FINE, ofs);
    rdchk(ADDR_IRQ_IF_CTRL, 8'h00);
    rdchk(ADDR_RND_ST_CTRL, 8'h00);
    host_u.wr(ADDR_IRQ_IF_CTRL, 8'hff);
    `CHK("sleep", 1'b1, sleep);
    `CHK("twi", 1'b0, twi);
    `CHK("lpf", 1'b1, lpf);
    rdchk(ADDR_IRQ_IF_CTRL, MSK_IRQ_IF_CTRL);
    host_u.wr(8'h16, 8'hff);
    rdchk(8'h16, 8'h00);
    host_u.idle = 2;
    for (int i = 0; i < 64; i++) begin
      v = {1'b0, 2'(i >> 4), 1'b0, 4'(i)};
      host_u.wr(ADDR_RND_ST_CTRL, v);
      `CHK("rnda", v[5], rnda);
      `CHK("rndg", v[6], rndg);
      `CHK("gst", v[3:2] == 2'h2 ? 2'h0 : v[3:2], gst);
      `CHK("ast", v[1:0] == 2'h3 ? 2'h0 : v[1:0], ast);
      `CHK("stbad", v[3:2] == 2'h2 || v[1:0] == 2'h3, stbad);
      rdchk(ADDR_RND_ST_CTRL, v);
    end
    host_u.idle = 0;
    for (int i = 0; i < 128; i++) begin
      v = {3'(i >> 4), 1'b0, 4'(i)};
      host_u.wr(ADDR_TRIG_FLT_CTRL, v);
      `CHK("bw", v[2:0], bw);
      `CHK("ofs", v[3] ? OFS_EXP_COARSE : OFS_EXP_FINE, ofs);
      `CHK("den", dmode(v[7:5]), data_enable_input);
    end
    for (int i = 0; i < 24; i++) begin
      host_u.wr(ADDR_IRQ_IF_CTRL, 8'($urandom) & MSK_IRQ_IF_CTRL);
      repeat (4) @(posedge clk);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("sleep", 1'b0, sleep);
    rdchk(ADDR_TRIG_FLT_CTRL, 8'h00);
    // let the last answer be matched before the verdict
    repeat (2) @(posedge clk);
    `CHK("pending", 8'h00, expq.size());
    complete_run();
  end
endmodule : tb_motion_sensor_control_regs
